// ==== verilog/eeprom_pkg.sv ====
package eeprom_pkg;
  // Timing of the system clock and of the internal write cycle
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned T_WR_MS     = 5;
  localparam int unsigned T_WR_CYC    = T_WR_MS * (CLK_HZ / 1000);
  // Array geometry
  localparam int unsigned MEM_AW      = 17;
  localparam int unsigned PAGE_AW     = 8;
  localparam int unsigned MEM_BYTES   = 1 << MEM_AW;
  localparam int unsigned PAGE_BYTES  = 1 << PAGE_AW;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  // Target address byte layout
  localparam logic [3:0]  ADDR_PREFIX = 4'hA;
  localparam int unsigned CTL_RW      = 0;
  localparam int unsigned CTL_TOP     = 1;
  // Bit counter value of the ninth clock
  localparam logic [3:0]  ACK_SLOT    = 4'h8;
  localparam logic [3:0]  MACK_SEEN   = 4'h9;
  // Master quarter bit time in clock cycles
  localparam int unsigned HOST_QTR    = 4;

  // Host command kinds
  typedef enum logic [1:0] {
    CMD_WRITE    = 2'b00,
    CMD_CUR_READ = 2'b01,
    CMD_SEL_READ = 2'b10,
    CMD_POLL     = 2'b11
  } cmd_kind_t;

  // Memory end byte phases
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_CTRL = 3'b001,
    D_ADRH = 3'b010,
    D_ADRL = 3'b011,
    D_DATA = 3'b100,
    D_READ = 3'b101
  } dev_st_t;

  // Master symbol states
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_START = 3'b001,
    H_BIT   = 3'b010,
    H_STOP  = 3'b011,
    H_WAIT  = 3'b100
  } host_st_t;

  // Master byte steps
  typedef enum logic [2:0] {
    P_CTRL  = 3'b000,
    P_AHI   = 3'b001,
    P_ALO   = 3'b010,
    P_DATA  = 3'b011,
    P_RCTRL = 3'b100,
    P_RDATA = 3'b101
  } host_step_t;
endpackage : eeprom_pkg

// ==== verilog/eeprom_bus_if.sv ====
`timescale 1ns/1ps
interface eeprom_bus_if;
  logic m_scl_o;   // Master clock level when enabled
  logic m_scl_oe;  // Master pulls clock
  logic m_sda_o;   // Master data level when enabled
  logic m_sda_oe;  // Master pulls data
  logic s_sda_o;   // Memory data level when enabled
  logic s_sda_oe;  // Memory pulls data
  logic scl;       // Resolved clock wire
  logic sda;       // Resolved data wire
  // Wired-AND with pull-ups: any enabled low driver wins
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
  modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input sda);
  modport dev (output s_sda_o, s_sda_oe, input scl, sda);
endinterface : eeprom_bus_if

// ==== verilog/eeprom_dev.sv ====
`timescale 1ns/1ps
module eeprom_dev
  import eeprom_pkg::*;
#(
  parameter int unsigned WR_CYCLES = T_WR_CYC  // Write cycle, above PAGE_BYTES
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  srst,
  // Two-wire bus
  eeprom_bus_if.dev  bus,
  // Straps and protect pin
  input  wire logic  strap_select_low,
  input  wire logic  strap_select_high,
  input  wire logic  write_protect,
  // Status
  output logic       busy
);

  // All control state in one record
  typedef struct packed {
    logic               scl_s1;   // Clock sync stage one
    logic               scl_s2;   // Clock sync stage two
    logic               scl_pv;   // Clock one cycle back
    logic               sda_s1;   // Data sync stage one
    logic               sda_s2;   // Data sync stage two
    logic               sda_pv;   // Data one cycle back
    logic               wp_s1;    // Protect sync stage one
    logic               wp_s2;    // Protect sync stage two
    logic [1:0]         str_s1;   // Strap sync stage one
    logic [1:0]         str_s2;   // Strap sync stage two, {high, low}
    dev_st_t            st;       // Byte phase
    logic [3:0]         bitcnt;   // Bits in current byte
    logic [7:0]         shreg;    // Received byte
    logic [7:0]         tx;       // Byte being sent
    logic               sda_oe;   // Pulling data low
    logic               in_ack;   // Driving our acknowledge
    logic               top;      // Address top bit
    logic [7:0]         hi;       // Address high byte
    logic [MEM_AW-1:0]  ptr;      // Address counter
    logic [MEM_AW-PAGE_AW-1:0] page;  // Page being loaded
    logic               wp_lat;   // Sampled protect level
    logic               pending;  // Data loaded, write on stop
    logic               busy;     // Programming in progress
    logic [31:0]        wcnt;     // Programming cycle counter
    logic [PAGE_BYTES-1:0] loaded;  // Bytes loaded this page
  } dev_state_t;

  dev_state_t q;                                 // Registered state
  dev_state_t d;                                 // Next state
  logic [7:0] mem [0:MEM_BYTES-1];              // Nonvolatile array
  logic [7:0] pbuf [0:PAGE_BYTES-1];            // Page write buffer
  logic [7:0] rd_byte;                          // Byte at counter
  logic       prog_we;                          // Array write strobe
  logic [PAGE_AW-1:0] prog_idx;                 // Array write offset
  logic       pb_we;                            // Buffer write strobe
  logic       scl_rise;                         // Clock rose
  logic       scl_fall;                         // Clock fell
  logic       start_c;                          // Start seen
  logic       stop_c;                           // Stop seen

  // Erased at delivery; real arrays keep contents, reset does not touch them
  initial begin
    for (int i = 0; i < MEM_BYTES; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end

  assign rd_byte = mem[q.ptr];

  // Edge and condition decode from synchronised copies only
  assign scl_rise = q.scl_s2 & ~q.scl_pv;
  assign scl_fall = ~q.scl_s2 & q.scl_pv;
  assign start_c  = q.scl_s2 & q.scl_pv & q.sda_pv & ~q.sda_s2;
  assign stop_c   = q.scl_s2 & q.scl_pv & ~q.sda_pv & q.sda_s2;

  // Next state
  always_comb begin
    d = q;
    prog_we = 1'b0;
    prog_idx = q.wcnt[PAGE_AW-1:0];
    pb_we = 1'b0;
    // Two-stage synchronisers
    d.scl_s1 = bus.scl;
    d.scl_s2 = q.scl_s1;
    d.scl_pv = q.scl_s2;
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    d.sda_pv = q.sda_s2;
    d.wp_s1 = write_protect;
    d.wp_s2 = q.wp_s1;
    d.str_s1 = {strap_select_high, strap_select_low};
    d.str_s2 = q.str_s1;
    // Programming walks the page first, then waits out the cycle
    if (q.busy) begin
      d.wcnt = q.wcnt + 32'd1;
      if (q.wcnt < PAGE_BYTES && q.loaded[prog_idx]) begin
        prog_we = 1'b1;
      end
      if (q.wcnt == WR_CYCLES - 1) begin
        d.busy = 1'b0;
        d.wcnt = '0;
      end
    end
    if (start_c) begin
      // New command, also a repeated start; unstopped data is dropped
      d.st = D_CTRL;
      d.bitcnt = '0;
      d.sda_oe = 1'b0;
      d.in_ack = 1'b0;
      d.pending = 1'b0;
    end else if (stop_c) begin
      // Launch programming only if data was accepted
      if (q.pending) begin
        d.busy = 1'b1;
        d.wcnt = '0;
      end
      d.pending = 1'b0;
      d.st = D_IDLE;
      d.sda_oe = 1'b0;
      d.in_ack = 1'b0;
    end else if (scl_fall && q.in_ack) begin
      // End of our ninth clock: release and move on
      d.in_ack = 1'b0;
      d.sda_oe = 1'b0;
      d.bitcnt = '0;
      if (q.st == D_DATA && !q.pending) begin
        d.wp_lat = q.wp_s2;
      end
      if (q.st == D_READ) begin
        d.tx = rd_byte;
        d.sda_oe = ~rd_byte[7];
        d.ptr = q.ptr + 17'h0_0001;
      end
    end else begin
      case (q.st)
        D_IDLE: begin
          // Bus ignored until a start
          d.sda_oe = 1'b0;
        end
        D_CTRL, D_ADRH, D_ADRL, D_DATA: begin
          if (scl_rise && q.bitcnt < ACK_SLOT) begin
            d.shreg = {q.shreg[6:0], q.sda_s2};
            d.bitcnt = q.bitcnt + 4'd1;
          end else if (scl_fall && q.bitcnt == ACK_SLOT) begin
            d.sda_oe = 1'b1;
            d.in_ack = 1'b1;
            case (q.st)
              D_CTRL: begin
                if (q.shreg[7:4] == ADDR_PREFIX && q.shreg[3:2] == q.str_s2 && !q.busy) begin
                  d.top = q.shreg[CTL_TOP];
                  d.st = q.shreg[CTL_RW] ? D_READ : D_ADRH;
                end else begin
                  // Mismatch or busy: stay off the line
                  d.sda_oe = 1'b0;
                  d.in_ack = 1'b0;
                  d.st = D_IDLE;
                end
              end
              D_ADRH: begin
                d.hi = q.shreg;
                d.st = D_ADRL;
              end
              D_ADRL: begin
                // Counter loaded here serves both writes and dummy writes
                d.ptr = {q.top, q.hi, q.shreg};
                d.page = {q.top, q.hi};
                d.loaded = '0;
                d.st = D_DATA;
              end
              default: begin
                if (q.wp_lat) begin
                  // Protected: refuse byte and whole request
                  d.sda_oe = 1'b0;
                  d.in_ack = 1'b0;
                  d.st = D_IDLE;
                end else begin
                  pb_we = 1'b1;
                  d.loaded[q.ptr[PAGE_AW-1:0]] = 1'b1;
                  d.ptr = {q.ptr[MEM_AW-1:PAGE_AW], q.ptr[PAGE_AW-1:0] + 8'h01};
                  d.pending = 1'b1;
                end
              end
            endcase
          end
        end
        D_READ: begin
          if (scl_rise) begin
            if (q.bitcnt < ACK_SLOT) begin
              d.bitcnt = q.bitcnt + 4'd1;
            end else if (q.bitcnt == ACK_SLOT) begin
              // Master acknowledge continues, refusal ends the read
              if (!q.sda_s2) begin
                d.bitcnt = MACK_SEEN;
              end else begin
                d.st = D_IDLE;
              end
            end
          end else if (scl_fall) begin
            if (q.bitcnt == MACK_SEEN) begin
              // Counter wraps at the end of memory by its width
              d.tx = rd_byte;
              d.sda_oe = ~rd_byte[7];
              d.ptr = q.ptr + 17'h0_0001;
              d.bitcnt = '0;
            end else if (q.bitcnt == ACK_SLOT) begin
              d.sda_oe = 1'b0;
            end else if (q.bitcnt != '0) begin
              d.tx = {q.tx[6:0], 1'b0};
              d.sda_oe = ~q.tx[6];
            end
          end
        end
        default: begin
          d.st = D_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Array and page buffer writes, no reset by nature
  always_ff @(posedge clk) begin
    if (prog_we) begin
      mem[{q.page, prog_idx}] <= pbuf[prog_idx];
    end
    if (pb_we) begin
      pbuf[q.ptr[PAGE_AW-1:0]] <= q.shreg;
    end
  end

  // Open drain: level always low, only the enable moves
  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = q.sda_oe;
  assign busy         = q.busy;

endmodule : eeprom_dev

// ==== verilog/eeprom_host.sv ====
`timescale 1ns/1ps
module eeprom_host
  import eeprom_pkg::*;
#(
  parameter int unsigned QTR   = HOST_QTR,  // Cycles per quarter bit
  parameter int unsigned LEN_W = 10         // Byte count width
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Two-wire bus
  eeprom_bus_if.host             bus,
  // Command port
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire cmd_kind_t         cmd_kind,
  input  wire logic [1:0]        cmd_strap,
  input  wire logic [MEM_AW-1:0] cmd_addr,
  input  wire logic [LEN_W-1:0]  cmd_len,
  // Write data stream
  input  wire logic              wr_valid,
  output logic                   wr_ready,
  input  wire logic [7:0]        wr_data,
  // Read data stream
  output logic                   rd_valid,
  input  wire logic              rd_ready,
  output logic [7:0]             rd_data,
  // Completion
  output logic                   done,
  output logic                   nack
);

  // All state in one record
  typedef struct packed {
    logic              sda_s1;     // Data sync stage one
    logic              sda_s2;     // Data sync stage two
    host_st_t          st;         // Symbol state
    logic [1:0]        ph;         // Quarter of symbol
    logic [7:0]        qc;         // Cycle in quarter
    logic [3:0]        bitn;       // Bit in byte
    logic [7:0]        sh;         // Shift register
    host_step_t        step;       // Byte in command
    cmd_kind_t         kind;       // Current command
    logic [1:0]        strap;      // Target straps
    logic [MEM_AW-1:0] addr;       // Target address
    logic [LEN_W-1:0]  left;       // Data bytes to go
    logic              scl_oe;     // Pulling clock low
    logic              sda_oe;     // Pulling data low
    logic              cmd_ready;  // Idle, will take a command
    logic              wr_ready;   // Taking a write byte
    logic              done;       // Command finished pulse
    logic              nack;       // Last command refused
    logic [7:0]        e0;         // Buffer head
    logic [7:0]        e1;         // Buffer tail
    logic              v0;         // Head valid
    logic              v1;         // Tail valid
  } host_state_t;

  host_state_t q;        // Registered state
  host_state_t d;        // Next state
  logic        tick;     // Quarter boundary
  logic        sym_end;  // Symbol boundary
  logic        rx;       // Receiving data bytes
  logic        push;     // Read byte complete
  logic [7:0]  pdat;     // Read byte

  assign tick    = (q.qc == 8'(QTR - 1));
  assign sym_end = tick && (q.ph == 2'd3);
  assign rx      = (q.step == P_RDATA);

  // Next state
  always_comb begin
    d = q;
    push = 1'b0;
    pdat = {q.sh[6:0], q.sda_s2};
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    d.done = 1'b0;
    // Quarter timing while a symbol runs; clock low in 0-1, high in 2-3
    if (q.st == H_START || q.st == H_BIT || q.st == H_STOP) begin
      d.qc = tick ? 8'h00 : q.qc + 8'h01;
      if (tick) begin
        d.ph = q.ph + 2'd1;
        case (d.ph)
          2'd0: d.scl_oe = 1'b1;
          2'd1: begin
            // Data changes only while clock is low
            if (q.st == H_START) d.sda_oe = 1'b0;
            else if (q.st == H_STOP) d.sda_oe = 1'b1;
            else if (q.bitn == ACK_SLOT) d.sda_oe = rx && (q.left != LEN_W'(1));
            else d.sda_oe = rx ? 1'b0 : ~q.sh[7];
          end
          2'd2: d.scl_oe = 1'b0;
          default: begin
            if (q.st == H_START) d.sda_oe = 1'b1;
            if (q.st == H_STOP) d.sda_oe = 1'b0;
          end
        endcase
      end
    end
    case (q.st)
      H_IDLE: begin
        d.cmd_ready = 1'b1;
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        if (cmd_valid && q.cmd_ready) begin
          d.cmd_ready = 1'b0;
          d.kind = cmd_kind;
          d.strap = cmd_strap;
          d.addr = cmd_addr;
          d.left = cmd_len;
          d.nack = 1'b0;
          d.step = P_CTRL;
          d.st = H_START;
          d.ph = 2'd0;
          d.qc = 8'h00;
          d.scl_oe = 1'b1;
        end
      end
      H_START: begin
        if (sym_end) begin
          d.sh = {ADDR_PREFIX, q.strap, q.addr[MEM_AW-1],
                  (q.step == P_RCTRL) || (q.kind == CMD_CUR_READ)};
          d.bitn = '0;
          d.st = H_BIT;
        end
      end
      H_BIT: begin
        if (sym_end) begin
          if (q.bitn < ACK_SLOT) begin
            d.sh = rx ? pdat : {q.sh[6:0], 1'b0};
            d.bitn = q.bitn + 4'd1;
            push = rx && (q.bitn == 4'd7);
          end else begin
            d.bitn = '0;
            if (rx) begin
              d.left = q.left - LEN_W'(1);
              d.st = (q.left == LEN_W'(1)) ? H_STOP : H_WAIT;
            end else if (q.sda_s2) begin
              d.nack = 1'b1;
              d.st = H_STOP;
            end else begin
              case (q.step)
                P_CTRL: begin
                  if (q.kind == CMD_POLL) d.st = H_STOP;
                  else if (q.kind == CMD_CUR_READ) begin
                    d.step = P_RDATA;
                    d.st = H_WAIT;
                  end else begin
                    d.step = P_AHI;
                    d.sh = q.addr[15:8];
                  end
                end
                P_AHI: begin
                  d.step = P_ALO;
                  d.sh = q.addr[7:0];
                end
                P_ALO: begin
                  if (q.kind == CMD_WRITE) begin
                    d.step = P_DATA;
                    d.st = H_WAIT;
                  end else begin
                    d.step = P_RCTRL;
                    d.st = H_START;
                  end
                end
                P_DATA: begin
                  d.left = q.left - LEN_W'(1);
                  d.st = (q.left == LEN_W'(1)) ? H_STOP : H_WAIT;
                end
                default: begin
                  d.step = P_RDATA;
                  d.st = H_WAIT;
                end
              endcase
            end
          end
        end
      end
      H_WAIT: begin
        // Clock held low while the user side stalls
        if (rx) begin
          if (!q.v1) d.st = H_BIT;
        end else if (q.wr_ready && wr_valid) begin
          d.wr_ready = 1'b0;
          d.sh = wr_data;
          d.st = H_BIT;
        end else begin
          d.wr_ready = wr_valid;
        end
      end
      default: begin
        if (sym_end) begin
          d.scl_oe = 1'b0;
          d.done = 1'b1;
          d.st = H_IDLE;
        end
      end
    endcase
    // Two-entry read buffer, pop before push
    if (q.v0 && rd_ready) begin
      d.e0 = q.e1;
      d.v0 = q.v1;
      d.v1 = 1'b0;
    end
    if (push) begin
      if (!d.v0) begin
        d.e0 = pdat;
        d.v0 = 1'b1;
      end else begin
        d.e1 = pdat;
        d.v1 = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Open drain pins and registered user outputs
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = q.scl_oe;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = q.sda_oe;
  assign cmd_ready    = q.cmd_ready;
  assign wr_ready     = q.wr_ready;
  assign rd_valid     = q.v0;
  assign rd_data      = q.e0;
  assign done         = q.done;
  assign nack         = q.nack;

endmodule : eeprom_host

// ==== verif/eeprom_bus_props.sv ====
`timescale 1ns/1ps
module eeprom_bus_props (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Drivers and wires
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic seen_ff; // A start was seen
  logic idle_ff; // Between a stop and the next start
  // Arms on the first start after reset
  always_ff @(posedge clk) begin
    if (srst) seen_ff <= 1'b0;
    else if (scl && $fell(sda)) seen_ff <= 1'b1;
  end
  // Bus free from reset or a stop until the next start
  always_ff @(posedge clk) begin
    if (srst) idle_ff <= 1'b1;
    else if (scl && $fell(sda)) idle_ff <= 1'b0;
    else if (scl && $rose(sda)) idle_ff <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_start; scl && $fell(sda); endsequence
  sequence s_stop; scl && $rose(sda); endsequence
  property p_od_s; s_sda_o == 1'b0; endproperty
  a_od_s: assert property (p_od_s)
    else $error("memory drives data high");
  property p_od_m; !m_sda_o && !m_scl_o; endproperty
  a_od_m: assert property (p_od_m)
    else $error("master drives a line high");
  // Memory moves data only with clock low
  property p_chg_low; $changed(s_sda_oe) |-> !scl && !$past(scl); endproperty
  a_chg_low: assert property (p_chg_low)
    else $error("memory data moved with clock high");
  property p_hi_len;
    $rose(scl) |-> ##[1:12] (!scl || (sda && !$past(sda)));
  endproperty
  a_hi_len: assert property (p_hi_len)
    else $error("clock high too long");
  property p_start_hold; s_start |-> scl [*2]; endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start not held");
  // Clock stays released for a bus free time after a stop
  property p_stop_end; s_stop |-> scl [*5]; endproperty
  a_stop_end: assert property (p_stop_end)
    else $error("bus not freed after stop");
  // Standby after a stop: memory keeps off the data line
  property p_idle_rel; idle_ff |-> !s_sda_oe; endproperty
  a_idle_rel: assert property (p_idle_rel)
    else $error("memory drives idle bus");
  property p_pre_start; !seen_ff |-> !s_sda_oe; endproperty
  a_pre_start: assert property (p_pre_start)
    else $error("memory drove before start");
endmodule : eeprom_bus_props

// ==== verif/tb_i2c_serial_eeprom_slave.sv ====
`timescale 1ns/1ps
module tb_i2c_serial_eeprom_slave;
  import eeprom_pkg::*;
  logic clk, srst, cmd_valid, cmd_ready, wr_valid, wr_ready;
  logic rd_valid, rd_ready, done, nack, busy, wp;
  logic [1:0] st, cmd_strap; // Straps and sent select bits
  cmd_kind_t cmd_kind;
  logic [16:0] cmd_addr, ptr, ba; // ptr models the counter
  logic [9:0] cmd_len;
  logic [7:0] wr_data, rd_data;
  logic rdy_w, rv; // Ready and valid as they stand for the coming edge
  logic [7:0] rd_c; // Read data as it stands for the coming edge
  logic [7:0] mem [logic [16:0]]; // Written bytes only
  logic [7:0] wq [$];
  logic [7:0] rq [$]; // Expected read bytes
  int error_cnt, n_tests, cyc;
  eeprom_bus_if bus_if ();
  eeprom_dev #(.WR_CYCLES(300)) u_eeprom_dev (.clk(clk), .srst(srst),
    .bus(bus_if.dev), .strap_select_low(st[0]), .strap_select_high(st[1]),
    .write_protect(wp), .busy(busy));
  eeprom_host #(.QTR(4)) u_eeprom_host (.clk(clk), .srst(srst),
    .bus(bus_if.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_strap(cmd_strap), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .done(done), .nack(nack));
  eeprom_bus_props u_eeprom_bus_props (.clk(clk), .srst(srst),
    .m_scl_o(bus_if.m_scl_o), .m_scl_oe(bus_if.m_scl_oe),
    .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe),
    .s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));
  task check(logic [7:0] s, logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t mismatch seen %h want %h", $time, s, e);
    end
  endtask : check
  task results();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // One command; model updated, expected bytes queued
  task run(cmd_kind_t k, logic [1:0] s, logic [16:0] a, int n, logic en);
    int i;
    logic [7:0] d;
    for (i = 0; i < n && k == CMD_WRITE; i++) begin
      d = 8'($urandom);
      wq.push_back(d);
      if (!en) mem[{a[16:8], a[7:0] + i[7:0]}] = d;
    end
    if (k == CMD_WRITE && !en) ptr = {a[16:8], a[7:0] + n[7:0]};
    if (k == CMD_SEL_READ) ptr = a;
    for (i = 0; i < n && k inside {CMD_CUR_READ, CMD_SEL_READ}; i++) begin
      rq.push_back(mem.exists(ptr) ? mem[ptr] : 8'hFF);
      ptr = ptr + 17'h0_0001;
    end
    cmd_kind = k;
    cmd_strap = s;
    cmd_addr = a;
    cmd_len = n[9:0];
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) begin @(posedge clk); #1; end
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    for (i = 0; i < 4000 && done !== 1'b1; i++) begin @(posedge clk); #1; end
    check(done, 1'b1);
    check(nack, en);
    wq.delete();
  endtask : run
  // Write stream feeder; ready taken after the edge, not at it, to avoid a race
  always @(posedge clk) begin
    if (wr_valid && rdy_w) void'(wq.pop_front());
    #1 wr_valid = wq.size() != 0;
    if (wq.size() != 0) wr_data = wq[0];
    rdy_w = wr_ready === 1'b1;
  end
  // Read monitor with random stalls; valid and data settled after the edge
  always @(posedge clk) begin
    if (rv && rd_ready) begin
      if (rq.size() == 0) check(rd_c, 8'hxx);
      else check(rd_c, rq.pop_front());
    end
    #1 rv = rd_valid === 1'b1;
    rd_c = rd_data;
    rd_ready = 1'($urandom % 2);
  end
  // Cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin error_cnt++; results(); end
  end
  initial begin clk = 0; forever #50 clk = ~clk; end
  initial begin
    {cmd_valid, wr_valid, rd_ready, wp, cmd_strap, cmd_len} = '0;
    {cmd_addr, wr_data, error_cnt, n_tests, cyc, ptr} = '0;
    cmd_kind = CMD_WRITE;
    srst = 1'b1;
    void'($urandom(32'h801c_027b));
    st = 2'($urandom);
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    repeat (5) @(posedge clk);
    #1 run(CMD_SEL_READ, st, 17'h1_FFFE, 3, 1'b0);
    run(CMD_WRITE, ~st, 17'h0_0040, 1, 1'b1);
    ba = {9'($urandom), 8'hFE};
    run(CMD_WRITE, st, ba, 4, 1'b0);
    check(busy, 1'b1);
    run(CMD_POLL, st, 17'h0_0000, 0, 1'b1);
    while (busy === 1'b1) @(posedge clk);
    #1 run(CMD_POLL, st, 17'h0_0000, 0, 1'b0);
    run(CMD_SEL_READ, st, {ba[16:8], 8'h00}, 3, 1'b0);
    run(CMD_SEL_READ, st, ba, 2, 1'b0);
    run(CMD_CUR_READ, st, 17'h0_0000, 1, 1'b0);
    wp = 1'b1;
    run(CMD_WRITE, st, ba - 17'h0_0100, 1, 1'b1);
    wp = 1'b0;
    check(busy, 1'b0);
    run(CMD_SEL_READ, st, ba - 17'h0_0100, 1, 1'b0);
    repeat (200) @(posedge clk);
    check(8'(rq.size()), 8'h00);
    results();
  end
endmodule : tb_i2c_serial_eeprom_slave
